// >>> anp_pkg.sv
// package for the per-port auto-negotiation status and next-page transmit bank
// assumes an AXI4-Lite master with 32-bit data and aligned word accesses
package anp_pkg;

    // ************************************************************
    // bus register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] IDX_CTRL = 8'h6E;
    localparam logic [7:0] IDX_OFFSET = 8'h6F;
    localparam logic [7:0] IDX_DATA = 8'hA0;

    // ************************************************************
    // indirect selection
    // ************************************************************
    localparam logic [2:0] TABLE_EEE = 3'h1;
    localparam logic [7:0] OFF_STAT_HI = 8'h0C;
    localparam logic [7:0] OFF_STAT_LO = 8'h0D;
    localparam logic [7:0] OFF_TX_HI = 8'h0E;
    localparam logic [7:0] OFF_TX_LO = 8'h0F;
    localparam logic [3:0] STAT_PORT_MAX = 4'h4;
    localparam logic [3:0] TX_PORT_MAX = 4'h3;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int CTRL_TABLE_LSB = 5;
    localparam int ST_LOC_ABLE = 6;
    localparam int ST_LOC_8H = 5;
    localparam int ST_PD_FAULT = 4;
    localparam int ST_LP_NP = 3;
    localparam int ST_NP_ABLE = 2;
    localparam int ST_PAGE_RX = 1;
    localparam int ST_LP_AN = 0;
    localparam int TXH_NP = 7;
    localparam int TXH_MP = 5;
    localparam int TXH_ACK2 = 4;
    localparam int TXH_TOGGLE = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam logic RST_LOC_8H = 1'b1;
    localparam logic RST_NP = 1'b0;
    localparam logic RST_MP = 1'b1;
    localparam logic RST_ACK2 = 1'b0;
    localparam logic RST_TOGGLE = 1'b0;

    // ************************************************************
    // axi responses
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // link partner state reported by the negotiation engine
    typedef struct packed {
        logic an_able;
        logic np_able;
        logic store_8h;
    } anp_partner_t;

    // controls presented to the next-page transmitter
    typedef struct packed {
        logic np;
        logic mp;
        logic ack2;
        logic toggle;
    } anp_tx_t;

endpackage

// >>> anp_regs.sv
// auto-negotiation expansion status word pair for each of STAT_PORTS ports, next-page transmit word pair for each of TX_PORTS ports
// assumes the negotiation engine gives one-cycle event pulses synchronous to aclk
`timescale 1ns/100ps

module anp_regs #(
    parameter int ADDR_W = 12,
    parameter int STAT_PORTS = 4,
    parameter int TX_PORTS = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire anp_pkg::anp_partner_t [STAT_PORTS-1:0] partner,
    input wire logic [STAT_PORTS-1:0] pd_fault_evt,
    input wire logic [STAT_PORTS-1:0] page_rx_evt,
    input wire logic [TX_PORTS-1:0] base_done_evt,
    input wire logic [TX_PORTS-1:0] base_toggle,
    input wire logic [TX_PORTS-1:0] np_done_evt,
    output anp_pkg::anp_tx_t [TX_PORTS-1:0] tx_word
);

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] ctrl;
    logic [7:0] offset;
    logic [STAT_PORTS-1:0] loc_8h;
    logic [STAT_PORTS-1:0] lp_np;
    logic [STAT_PORTS-1:0] lp_an;
    logic [STAT_PORTS-1:0] pd_fault;
    logic [STAT_PORTS-1:0] page_rx;
    logic [STAT_PORTS-1:0] clr_pd;
    logic [STAT_PORTS-1:0] clr_pg;
    logic [ADDR_W-1:0] aw_addr;
    logic aw_have;
    logic [7:0] w_byte;
    logic [3:0] w_strb;
    logic w_have;
    logic [7:0] next_rbyte;
    logic next_rok;

    // indirect target hit: table and port range (1 to maxp), offset checked by the caller
    function automatic logic sel_hit(input logic [7:0] c, input logic [3:0] maxp);
        sel_hit = (c[7:anp_pkg::CTRL_TABLE_LSB] == anp_pkg::TABLE_EEE) && (c[3:0] != 4'h0)
            && (c[3:0] <= maxp);
    endfunction

    // bus word index of a byte address
    function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
        word_idx = a[9:2];
    endfunction

    logic [3:0] port_sel;
    logic [1:0] port_idx;
    logic stat_sel;
    logic tx_sel;
    assign port_sel = ctrl[3:0];
    assign port_idx = 2'(port_sel - 4'h1);
    assign stat_sel = sel_hit(ctrl, 4'(STAT_PORTS));
    assign tx_sel = sel_hit(ctrl, 4'(TX_PORTS));

    // ************************************************************
    // read byte selection
    // ************************************************************
    always_comb begin
        next_rbyte = 8'h00;
        next_rok = 1'b1;
        if (word_idx(s_axi_araddr) == anp_pkg::IDX_CTRL) begin
            next_rbyte = ctrl;
        end else if (word_idx(s_axi_araddr) == anp_pkg::IDX_OFFSET) begin
            next_rbyte = offset;
        end else if (word_idx(s_axi_araddr) == anp_pkg::IDX_DATA) begin
            if (stat_sel && offset == anp_pkg::OFF_STAT_HI) begin
                next_rbyte = 8'h00;
            end else if (stat_sel && offset == anp_pkg::OFF_STAT_LO) begin
                next_rbyte[anp_pkg::ST_LOC_ABLE] = 1'b1;
                next_rbyte[anp_pkg::ST_LOC_8H] = loc_8h[port_idx];
                next_rbyte[anp_pkg::ST_PD_FAULT] = pd_fault[port_idx];
                next_rbyte[anp_pkg::ST_LP_NP] = lp_np[port_idx];
                next_rbyte[anp_pkg::ST_NP_ABLE] = 1'b1;
                next_rbyte[anp_pkg::ST_PAGE_RX] = page_rx[port_idx];
                next_rbyte[anp_pkg::ST_LP_AN] = lp_an[port_idx];
            end else if (tx_sel && offset == anp_pkg::OFF_TX_HI) begin
                next_rbyte[anp_pkg::TXH_NP] = tx_word[port_idx].np;
                next_rbyte[anp_pkg::TXH_MP] = tx_word[port_idx].mp;
                next_rbyte[anp_pkg::TXH_ACK2] = tx_word[port_idx].ack2;
                next_rbyte[anp_pkg::TXH_TOGGLE] = tx_word[port_idx].toggle;
            end
        end else begin
            next_rok = 1'b0;
        end
    end

    // ************************************************************
    // read channel
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= anp_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, next_rbyte};
            s_axi_rresp <= next_rok ? anp_pkg::RESP_OKAY : anp_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ************************************************************
    // latched-high status bits
    // ************************************************************
    // pending clears armed at address capture, disarmed by a recurring event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clr_pd <= '0;
            clr_pg <= '0;
            pd_fault <= '0;
            page_rx <= '0;
        end else begin
            for (int p = 0; p < STAT_PORTS; p++) begin
                if (s_axi_arvalid && s_axi_arready) begin
                    clr_pd[p] <= 1'b0;
                    clr_pg[p] <= 1'b0;
                    if (word_idx(s_axi_araddr) == anp_pkg::IDX_DATA && stat_sel
                        && offset == anp_pkg::OFF_STAT_LO && port_idx == 2'(p)) begin
                        clr_pd[p] <= !pd_fault_evt[p];
                        clr_pg[p] <= !page_rx_evt[p];
                    end
                end else if (s_axi_rvalid && s_axi_rready) begin
                    clr_pd[p] <= 1'b0;
                    clr_pg[p] <= 1'b0;
                end else begin
                    if (pd_fault_evt[p]) begin
                        clr_pd[p] <= 1'b0;
                    end
                    if (page_rx_evt[p]) begin
                        clr_pg[p] <= 1'b0;
                    end
                end
                if (pd_fault_evt[p]) begin
                    pd_fault[p] <= 1'b1;
                end else if (s_axi_rvalid && s_axi_rready && clr_pd[p]) begin
                    pd_fault[p] <= 1'b0;
                end
                if (page_rx_evt[p]) begin
                    page_rx[p] <= 1'b1;
                end else if (s_axi_rvalid && s_axi_rready && clr_pg[p]) begin
                    page_rx[p] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // partner ability mirrors
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loc_8h <= {STAT_PORTS{anp_pkg::RST_LOC_8H}};
            lp_np <= '0;
            lp_an <= '0;
        end else begin
            for (int p = 0; p < STAT_PORTS; p++) begin
                loc_8h[p] <= partner[p].store_8h;
                lp_np[p] <= partner[p].np_able;
                lp_an[p] <= partner[p].an_able;
            end
        end
    end

    // ************************************************************
    // write channel
    // ************************************************************
    // address and data captured in either order, answer once both are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= anp_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_have <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_byte <= s_axi_wdata[7:0];
                w_strb <= s_axi_wstrb;
                w_have <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_have && w_have) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (word_idx(aw_addr) == anp_pkg::IDX_CTRL
                    || word_idx(aw_addr) == anp_pkg::IDX_OFFSET
                    || word_idx(aw_addr) == anp_pkg::IDX_DATA) ? anp_pkg::RESP_OKAY : anp_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    logic wr_go;
    assign wr_go = aw_have && w_have && w_strb[0];

    // ************************************************************
    // selector registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= anp_pkg::CTRL_RESET;
            offset <= anp_pkg::OFFSET_RESET;
        end else if (wr_go && word_idx(aw_addr) == anp_pkg::IDX_CTRL) begin
            ctrl <= {w_byte[7:5], 1'b0, w_byte[3:0]};
        end else if (wr_go && word_idx(aw_addr) == anp_pkg::IDX_OFFSET) begin
            offset <= w_byte;
        end
    end

    // ************************************************************
    // next-page transmit words
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int p = 0; p < TX_PORTS; p++) begin
                tx_word[p].np <= anp_pkg::RST_NP;
                tx_word[p].mp <= anp_pkg::RST_MP;
                tx_word[p].ack2 <= anp_pkg::RST_ACK2;
                tx_word[p].toggle <= anp_pkg::RST_TOGGLE;
            end
        end else begin
            for (int p = 0; p < TX_PORTS; p++) begin
                if (wr_go && word_idx(aw_addr) == anp_pkg::IDX_DATA && tx_sel
                    && offset == anp_pkg::OFF_TX_HI && port_idx == 2'(p)) begin
                    tx_word[p].np <= w_byte[anp_pkg::TXH_NP];
                    tx_word[p].mp <= w_byte[anp_pkg::TXH_MP];
                    tx_word[p].ack2 <= w_byte[anp_pkg::TXH_ACK2];
                end
                if (base_done_evt[p]) begin
                    tx_word[p].toggle <= !base_toggle[p];
                end else if (np_done_evt[p]) begin
                    tx_word[p].toggle <= !tx_word[p].toggle;
                end
            end
        end
    end

endmodule

// >>> anp_regs_asserts.sv
// concurrent checks on the ports of the next-page port register bank
// assumes it is bound onto anp_regs with the same parameters
`timescale 1ns/100ps
module anp_regs_asserts #(
    parameter int ADDR_W = 12,
    parameter int STAT_PORTS = 4,
    parameter int TX_PORTS = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic [TX_PORTS-1:0] base_done_evt,
    input wire logic [TX_PORTS-1:0] base_toggle,
    input wire logic [TX_PORTS-1:0] np_done_evt,
    input wire anp_pkg::anp_tx_t [TX_PORTS-1:0] tx_word
);
    // ************************************************************
    // bus and transmit word checks
    // ************************************************************
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    rdata_high_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    data_okay_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(12'h280)
        |=> s_axi_rresp == anp_pkg::RESP_OKAY)
        else $error("data register not okay");
    unmapped_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(12'h004)
        |=> s_axi_rresp == anp_pkg::RESP_SLVERR)
        else $error("unmapped read not refused");
    tx_reset_a: assert property ($rose(aresetn) |-> tx_word[0] == 4'h4)
        else $error("transmit word reset wrong");
    first_toggle_a: assert property (base_done_evt[0] |=> tx_word[0].toggle == !$past(base_toggle[0]))
        else $error("first toggle not inverse of base");
    next_toggle_a: assert property (np_done_evt[0] && !base_done_evt[0]
        |=> tx_word[0].toggle != $past(tx_word[0].toggle))
        else $error("toggle did not flip");
    toggle_hold_a: assert property (!np_done_evt[0] && !base_done_evt[0] |=> $stable(tx_word[0].toggle))
        else $error("toggle moved without exchange");
    // main scenarios reached
    cover property (base_done_evt[0]);
    cover property (np_done_evt[0]);
    cover property (s_axi_rvalid && s_axi_rresp == anp_pkg::RESP_SLVERR);
endmodule

// >>> anp_lp_model.sv
// link partner model: ability levels and exchange event pulses
// assumes its task is called just after a rising aclk edge
`timescale 1ns/100ps
module anp_lp_model #(
    parameter int STAT_PORTS = 4,
    parameter int TX_PORTS = 3
) (
    input wire logic aclk,
    output anp_pkg::anp_partner_t [STAT_PORTS-1:0] partner,
    output logic [STAT_PORTS-1:0] pd_fault_evt,
    output logic [STAT_PORTS-1:0] page_rx_evt,
    output logic [TX_PORTS-1:0] base_done_evt,
    output logic [TX_PORTS-1:0] base_toggle,
    output logic [TX_PORTS-1:0] np_done_evt
);
    // idle partner: no abilities, pages kept in register 8h
    initial begin
        partner = {STAT_PORTS{3'h1}};
        pd_fault_evt = '0;
        page_rx_evt = '0;
        base_done_evt = '0;
        base_toggle = '0;
        np_done_evt = '0;
    end
    // ability levels for every port
    task automatic set_ab(input logic an, input logic np, input logic s8);
        @(posedge aclk);
        partner <= {STAT_PORTS{an, np, s8}};
    endtask
    // one-cycle events, then an idle edge so results have landed
    task automatic ev(input logic [3:0] pd, input logic [3:0] pg, input logic [2:0] bd,
                      input logic [2:0] bt, input logic [2:0] nd);
        @(posedge aclk);
        pd_fault_evt <= pd;
        page_rx_evt <= pg;
        base_done_evt <= bd;
        base_toggle <= bt;
        np_done_evt <= nd;
        @(posedge aclk);
        pd_fault_evt <= '0;
        page_rx_evt <= '0;
        base_done_evt <= '0;
        base_toggle <= ~bt; // stale value never shown outside the pulse
        np_done_evt <= '0;
        @(posedge aclk);
    endtask
endmodule

// >>> anp_regs_tb_top.sv
// self-checking bench for the next-page port register bank
// assumes anp_pkg, anp_regs, anp_lp_model and anp_regs_asserts compiled first
`timescale 1ns/100ps
module anp_regs_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic [1:0] bresp, rresp;
    anp_pkg::anp_partner_t [3:0] partner;
    logic [3:0] pd_fault_evt, page_rx_evt;
    logic [2:0] base_done_evt, base_toggle, np_done_evt;
    anp_pkg::anp_tx_t [2:0] tx_word;
    int errors = 0;
    int num_checks = 0;
    // 50 MHz clock
    always #10 aclk = ~aclk;
    anp_regs dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .partner(partner), .pd_fault_evt(pd_fault_evt), .page_rx_evt(page_rx_evt),
        .base_done_evt(base_done_evt), .base_toggle(base_toggle), .np_done_evt(np_done_evt), .tx_word(tx_word)
    );
    anp_lp_model lp (
        .aclk(aclk), .partner(partner), .pd_fault_evt(pd_fault_evt), .page_rx_evt(page_rx_evt),
        .base_done_evt(base_done_evt), .base_toggle(base_toggle), .np_done_evt(np_done_evt)
    );
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic c, input string m);
        num_checks++;
        if (c !== 1'b1) begin
            errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    function automatic logic [11:0] ba(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction
    // write: address and data offered together, each released when taken
    task automatic bw(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ha, hw, hb = 1'b0;
        logic [1:0] r;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40 && !hb; n++) begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        // one idle edge so the next request never re-raises bready in this step
        @(posedge aclk);
        chk(hb && r === er, "write response");
    endtask
    task automatic br(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
        logic ha, hr = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40 && !hr; n++) begin
            @(negedge aclk);
            ha = arvalid && arready;
            hr = rvalid && rready;
            d = rdata[7:0];
            r = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        // one idle edge so the next request never re-raises rready in this step
        @(posedge aclk);
        chk(hr, "read answer");
    endtask
    // select table, port and byte offset, then move the byte
    task automatic sel(input logic [3:0] p, input logic [7:0] o);
        bw(ba(anp_pkg::IDX_CTRL), {anp_pkg::TABLE_EEE, 1'b0, p}, anp_pkg::RESP_OKAY);
        bw(ba(anp_pkg::IDX_OFFSET), o, anp_pkg::RESP_OKAY);
    endtask
    task automatic put(input logic [3:0] p, input logic [7:0] o, input logic [7:0] v);
        sel(p, o);
        bw(ba(anp_pkg::IDX_DATA), v, anp_pkg::RESP_OKAY);
    endtask
    task automatic eb(input logic [3:0] p, input logic [7:0] o, input logic [7:0] e, input string m);
        logic [7:0] d;
        logic [1:0] r;
        sel(p, o);
        br(ba(anp_pkg::IDX_DATA), d, r);
        chk(d === e && r === anp_pkg::RESP_OKAY, m);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        for (int p = 1; p <= 4; p++) begin
            eb(4'(p), anp_pkg::OFF_STAT_LO, 8'h64, "status reset");
            eb(4'(p), anp_pkg::OFF_STAT_HI, 8'h00, "status upper");
        end
        for (int p = 1; p <= 3; p++) eb(4'(p), anp_pkg::OFF_TX_HI, 8'h20, "tx reset");
    endtask
    task automatic t_partner();
        lp.set_ab(1'b1, 1'b1, 1'b0);
        for (int p = 1; p <= 4; p++) eb(4'(p), anp_pkg::OFF_STAT_LO, 8'h4D, "partner");
        lp.set_ab(1'b0, 1'b0, 1'b1);
        eb(4'h4, anp_pkg::OFF_STAT_LO, 8'h64, "partner gone");
    endtask
    task automatic t_latch();
        logic [7:0] d;
        logic [1:0] r;
        lp.ev(4'h2, 4'h4, 3'h0, 3'h0, 3'h0);
        eb(4'h2, anp_pkg::OFF_STAT_HI, 8'h00, "upper read");
        eb(4'h2, anp_pkg::OFF_STAT_LO, 8'h74, "fault held");
        eb(4'h2, anp_pkg::OFF_STAT_LO, 8'h64, "fault clear");
        eb(4'h3, anp_pkg::OFF_STAT_LO, 8'h66, "page held");
        eb(4'h3, anp_pkg::OFF_STAT_LO, 8'h64, "page clear");
        eb(4'h1, anp_pkg::OFF_STAT_LO, 8'h64, "port apart");
        // fault pulse lands on the edge that completes a clearing read
        sel(4'h2, anp_pkg::OFF_STAT_LO);
        fork
            br(ba(anp_pkg::IDX_DATA), d, r);
            lp.ev(4'h2, 4'h0, 3'h0, 3'h0, 3'h0);
        join
        chk(d === 8'h64 && r === anp_pkg::RESP_OKAY, "read before event");
        eb(4'h2, anp_pkg::OFF_STAT_LO, 8'h74, "event kept");
        eb(4'h2, anp_pkg::OFF_STAT_LO, 8'h64, "event cleared");
    endtask
    task automatic t_tx();
        put(4'h1, anp_pkg::OFF_TX_HI, 8'hFF);
        eb(4'h1, anp_pkg::OFF_TX_HI, 8'hB0, "tx write");
        chk(tx_word[0] === 4'hE, "tx out");
        eb(4'h2, anp_pkg::OFF_TX_HI, 8'h20, "tx port apart");
        put(4'h1, anp_pkg::OFF_TX_HI, 8'h00);
        eb(4'h1, anp_pkg::OFF_TX_HI, 8'h00, "tx clear");
        put(4'h1, anp_pkg::OFF_TX_LO, 8'hFF);
        eb(4'h1, anp_pkg::OFF_TX_LO, 8'h00, "tx low");
        put(4'h4, anp_pkg::OFF_TX_HI, 8'hFF);
        eb(4'h4, anp_pkg::OFF_TX_HI, 8'h00, "no tx port 4");
        put(4'h1, anp_pkg::OFF_STAT_LO, 8'hFF);
        eb(4'h1, anp_pkg::OFF_STAT_LO, 8'h64, "status ro");
    endtask
    task automatic t_toggle();
        lp.ev(4'h0, 4'h0, 3'h1, 3'h0, 3'h0);
        eb(4'h1, anp_pkg::OFF_TX_HI, 8'h08, "first toggle");
        lp.ev(4'h0, 4'h0, 3'h0, 3'h0, 3'h1);
        eb(4'h1, anp_pkg::OFF_TX_HI, 8'h00, "toggle flip");
        lp.ev(4'h0, 4'h0, 3'h0, 3'h0, 3'h1);
        chk(tx_word[0].toggle === 1'b1, "toggle flip");
        lp.ev(4'h0, 4'h0, 3'h5, 3'h1, 3'h0);
        eb(4'h1, anp_pkg::OFF_TX_HI, 8'h00, "base one");
        eb(4'h3, anp_pkg::OFF_TX_HI, 8'h28, "base zero");
    endtask
    task automatic t_bus();
        logic [7:0] d;
        logic [1:0] r;
        br(12'h004, d, r);
        chk(r === anp_pkg::RESP_SLVERR && d === 8'h00, "unmapped read");
        bw(12'h004, 8'hFF, anp_pkg::RESP_SLVERR);
    endtask
    task automatic test_done();
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // main sequence after 20 reset cycles
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_partner();
        t_latch();
        t_tx();
        t_toggle();
        t_bus();
        test_done();
    end
    // watchdog well beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        test_done();
    end
endmodule
bind anp_regs anp_regs_asserts #(.ADDR_W(ADDR_W), .STAT_PORTS(STAT_PORTS), .TX_PORTS(TX_PORTS)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .base_done_evt(base_done_evt), .base_toggle(base_toggle), .np_done_evt(np_done_evt), .tx_word(tx_word)
);
